// *** pkg/tpd_regs.svh ***
// Register offsets, field positions, reset values and timing counts
// Assumes inclusion by the phase demand controller and testbench only
`ifndef TPD_REGS_SVH
`define TPD_REGS_SVH
`define TPD_NPH         4
`define TPD_CFG_OFS     8'h00
`define TPD_TIMA_OFS    8'h10
`define TPD_TIMB_OFS    8'h20
`define TPD_STAT_OFS    8'h30
`define TPD_CFG_RST     32'h00f0_0000
`define TPD_TIMA_RST    32'h1e64_6446
`define TPD_TIMB_RST    32'h0014_28c8
`define TPD_F_VMOFF     0
`define TPD_F_MINREC    4
`define TPD_F_MAXREC    8
`define TPD_F_PEDREC    12
`define TPD_F_NONACT    16
`define TPD_F_PEDEQ     20
`define TPD_B_WALK      0
`define TPD_B_PCLR      1
`define TPD_B_MING      2
`define TPD_B_PASS      3
`define TPD_B_MAX       0
`define TPD_B_YEL       1
`define TPD_B_RED       2
`define TPD_TICK_MS     100
`define TPD_CLK_NS      25
`define TPD_FLASH_TICKS 8'h05
`define TPD_RESP_OK     2'b00
`define TPD_RESP_ERR    2'b10
`endif

// *** pkg/tpd_pkg.sv ***
// Types shared by the phase demand controller
// Assumes nothing beyond a SystemVerilog compiler
package tpd_pkg;
  typedef enum logic [3:0] {
    S_WALK, S_WHOLD, S_PCLR, S_GREST, S_GRN, S_YEL, S_RCLR, S_RREST
  } tpd_state_t;
  typedef enum logic [1:0] {P_DW, P_WALK, P_CLR} tpd_ped_t;
  typedef logic [1:0] tpd_ph_t;
endpackage

// *** hw/tpd_sync.sv ***
// Two-stage synchroniser for pin inputs
// Assumes the pins are asynchronous to CORE_CLK
module tpd_sync #(parameter int W = 1) (
  // Clocking
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         ce,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta <= '0;
      q    <= '0;
    end else if (ce) begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

// *** hw/tpd_ctrl.sv ***
// Four-phase single-ring demand, sequencing and load-switch logic
// Assumes pins are asynchronous, AXI4-Lite master on CORE_CLK
`include "tpd_regs.svh"
module tpd_ctrl import tpd_pkg::*; #(
  parameter int TICK_CYC = `TPD_TICK_MS * 1000000 / `TPD_CLK_NS
) (
  // Clocking
  input  wire logic       CORE_CLK,
  input  wire logic       SYS_RST,
  input  wire logic       CE,
  // Detector and coordination pins
  input  wire logic [3:0] VEH_DET,
  input  wire logic [3:0] PED_DET,
  input  wire logic       HOLD,
  input  wire logic       PED_RECYCLE,
  input  wire logic [3:0] PHASE_SKIP,
  input  wire logic [3:0] PED_SKIP,
  // Load switch drivers and status
  output logic      [3:0] GRN_OUT,
  output logic      [3:0] YEL_OUT,
  output logic      [3:0] RED_OUT,
  output logic      [3:0] WALK_OUT,
  output logic      [3:0] PCLR_OUT,
  output logic      [3:0] DW_OUT,
  output logic      [3:0] CALL_OUT,
  output logic      [3:0] ACTIVE_OUT,
  output logic      [3:0] UPCOMING_OUT,
  // AXI4-Lite slave
  input  wire logic [7:0] AWADDR,
  input  wire logic       AWVALID,
  output logic            AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0] WSTRB,
  input  wire logic       WVALID,
  output logic            WREADY,
  output logic      [1:0] BRESP,
  output logic            BVALID,
  input  wire logic       BREADY,
  input  wire logic [7:0] ARADDR,
  input  wire logic       ARVALID,
  output logic            ARREADY,
  output logic     [31:0] RDATA,
  output logic      [1:0] RRESP,
  output logic            RVALID,
  input  wire logic       RREADY
);
  function automatic logic [7:0] fld(input logic [31:0] w, input int b);
    fld = w[b*8 +: 8];
  endfunction
  function automatic logic [7:0] dec(input logic [7:0] x, input logic t);
    dec = (t && x != 8'h00) ? x - 8'h01 : x;
  endfunction
  // First demanding phase after c, wrapping round to c itself
  function automatic logic [2:0] pick(input logic [3:0] d,
                                      input tpd_ph_t c);
    logic [2:0] r;
    tpd_ph_t    k;
    r = 3'h0;
    for (int i = 4; i >= 1; i--) begin
      k = tpd_ph_t'(c + 2'(i));
      if (d[k]) r = {1'b1, k};
    end
    pick = r;
  endfunction
  function automatic logic [31:0] merge(input logic [31:0] o,
                                        input logic [31:0] n,
                                        input logic [3:0]  s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) if (s[i]) r[i*8 +: 8] = n[i*8 +: 8];
    merge = r;
  endfunction

  logic [17:0] pins_s;
  logic [3:0]  vdet, pdet, skip, pskip;
  logic        hold, precyc;
  tpd_sync #(.W(18)) u_sync (
    .clk (CORE_CLK),
    .rst (SYS_RST),
    .ce  (CE),
    .d   ({VEH_DET, PED_DET, PHASE_SKIP, PED_SKIP, HOLD, PED_RECYCLE}),
    .q   (pins_s)
  );
  assign {vdet, pdet, skip, pskip, hold, precyc} = pins_s;

  logic [31:0] cfg;
  logic [31:0] tima [4];
  logic [31:0] timb [4];
  tpd_state_t  st, next_st;
  tpd_ped_t    pm, next_pm;
  tpd_ph_t     cur, next_cur, nxt, next_nxt;
  logic        nok, next_nok, mrun, next_mrun;
  logic [7:0]  pcnt, tmr, ming, pass, maxc;
  logic [7:0]  next_pcnt, next_tmr, next_ming, next_pass, next_maxc;
  logic [3:0]  vcall, pcall, next_vcall, next_pcall;
  logic [31:0] tcnt;
  logic [7:0]  fcnt;
  logic        flash, end_grn;

  wire tk = (tcnt == TICK_CYC - 1);
  wire [3:0] vmoff  = cfg[`TPD_F_VMOFF +: 4];
  wire [3:0] minrec = cfg[`TPD_F_MINREC +: 4];
  wire [3:0] maxrec = cfg[`TPD_F_MAXREC +: 4];
  wire [3:0] pedrec = cfg[`TPD_F_PEDREC +: 4];
  wire [3:0] nonact = cfg[`TPD_F_NONACT +: 4];
  wire [3:0] pedeq  = cfg[`TPD_F_PEDEQ +: 4];
  wire grn_st = st == S_WALK || st == S_WHOLD || st == S_PCLR ||
                st == S_GREST || st == S_GRN;
  wire [3:0] cur_oh = 4'h1 << cur;
  wire [3:0] g      = grn_st ? cur_oh : 4'h0;
  wire [3:0] walk_a = (grn_st && pm == P_WALK) ? cur_oh : 4'h0;
  // Skipped phases never count as demand or conflict
  wire [3:0] dem  = ~skip & (vcall | (pcall & ~pskip & pedeq));
  wire conf       = |(dem & ~cur_oh);
  wire [2:0] pk   = pick(dem, cur);
  wire ped_ok     = pcall[cur] && !pskip[cur] && pedeq[cur];
  wire recyc      = pm == P_DW && ped_ok &&
                    (hold ? precyc : !conf);
  wire leave      = end_grn && pass != 8'h00 && !vmoff[cur];
  // Recalls feed outside green only, so no recycle in the same green
  wire [3:0] vset = ~g & (vdet | minrec | nonact);
  wire [3:0] pset = pedeq & ~walk_a & (pdet | (pedrec & ~g));

  always_comb begin
    logic       go;
    tpd_ph_t    gph;
    go = 1'b0;
    gph = cur;
    end_grn = 1'b0;
    next_st = st;
    next_cur = cur;
    next_nxt = nxt;
    next_nok = nok;
    next_pm = pm;
    next_mrun = mrun || (st == S_GRN && (conf || maxrec[cur]));
    next_pcnt = dec(pcnt, tk);
    next_tmr = dec(tmr, tk);
    next_ming = dec(ming, tk);
    next_pass = dec(pass, tk);
    next_maxc = mrun ? dec(maxc, tk) : maxc;
    case (st)
      S_WALK: if (pcnt == 8'h00) begin
        if (hold) next_st = S_WHOLD;
        else begin
          next_st = S_PCLR;
          next_pm = P_CLR;
          next_pcnt = fld(tima[cur], `TPD_B_PCLR);
        end
      end
      S_WHOLD: if (!hold) begin
        next_st = S_PCLR;
        next_pm = P_CLR;
        next_pcnt = fld(tima[cur], `TPD_B_PCLR);
      end
      S_PCLR: begin
        if (pcnt == 8'h00) next_pm = P_DW;
        if (pcnt == 8'h00 && ming == 8'h00) next_st = S_GREST;
      end
      S_GREST: begin
        if (conf) end_grn = 1'b1;
        else if (precyc && ped_ok) begin
          next_st = S_WALK;
          next_pm = P_WALK;
          next_pcnt = fld(tima[cur], `TPD_B_WALK);
        end
      end
      S_GRN: begin
        if (vdet[cur]) next_pass = fld(tima[cur], `TPD_B_PASS);
        if (pm == P_WALK && pcnt == 8'h00) begin
          next_pm = P_CLR;
          next_pcnt = fld(tima[cur], `TPD_B_PCLR);
        end else if (pm == P_CLR && pcnt == 8'h00) next_pm = P_DW;
        else if (recyc) begin
          next_pm = P_WALK;
          next_pcnt = fld(tima[cur], `TPD_B_WALK);
        end else if (pm == P_DW && ming == 8'h00 && conf && !hold &&
                     (pass == 8'h00 || (mrun && maxc == 8'h00)))
          end_grn = 1'b1;
      end
      S_YEL: if (tmr == 8'h00) begin
        next_st = S_RCLR;
        next_tmr = fld(timb[cur], `TPD_B_RED);
      end
      S_RCLR: if (tmr == 8'h00) begin
        if (nok) begin
          go = 1'b1;
          gph = nxt;
        end else if (pk[2]) begin
          go = 1'b1;
          gph = pk[1:0];
        end else next_st = S_RREST;
      end
      S_RREST: if (pk[2]) begin
        go = 1'b1;
        gph = pk[1:0];
      end
      default: next_st = S_RREST;
    endcase
    if (end_grn) begin
      next_st = S_YEL;
      next_pm = P_DW;
      next_tmr = fld(timb[cur], `TPD_B_YEL);
      next_nok = pk[2];
      next_nxt = pk[1:0];
    end
    if (go) begin
      next_cur = gph;
      next_nok = 1'b0;
      next_mrun = 1'b0;
      next_ming = fld(tima[gph], `TPD_B_MING);
      next_pass = fld(tima[gph], `TPD_B_PASS);
      next_maxc = fld(timb[gph], `TPD_B_MAX);
      next_pcnt = fld(tima[gph], `TPD_B_WALK);
      next_pm = P_DW;
      next_st = S_GRN;
      if (nonact[gph]) begin
        next_st = S_WALK;
        next_pm = P_WALK;
      end else if (pcall[gph] && !pskip[gph] && pedeq[gph])
        next_pm = P_WALK;
    end
  end

  // Set terms after clear, but vset and pset share the g and walk_a masks: a new call survives only the vmoff clear
  assign next_vcall = (vcall & ~g & ~vmoff) | vset |
                      (leave ? cur_oh : 4'h0);
  assign next_pcall = (pcall & ~walk_a) | pset;

  wire [3:0] p_grn = next_st inside {S_WALK, S_WHOLD, S_PCLR, S_GREST,
                     S_GRN} ? 4'h1 << next_cur : 4'h0;
  wire [3:0] p_yel = next_st == S_YEL ? 4'h1 << next_cur : 4'h0;
  wire [3:0] p_on  = next_st != S_RREST ? 4'h1 << next_cur : 4'h0;
  wire [3:0] p_wk  = next_pm == P_WALK ? p_grn : 4'h0;
  wire [3:0] p_cl  = next_pm == P_CLR ? p_grn : 4'h0;
  wire [3:0] p_dw  = ~p_wk & ~(p_cl & {4{flash}});
  wire [3:0] p_chk = ~p_grn & (next_vcall | next_pcall);

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      tcnt <= 32'h0;
      fcnt <= 8'h00;
      flash <= 1'b0;
    end else if (CE) begin
      tcnt <= tk ? 32'h0 : tcnt + 32'h1;
      if (tk) fcnt <= (fcnt == `TPD_FLASH_TICKS - 8'h01) ? 8'h00
                                                  : fcnt + 8'h01;
      if (tk && fcnt == `TPD_FLASH_TICKS - 8'h01) flash <= !flash;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      st <= S_RREST;
      pm <= P_DW;
      {cur, nxt, nok, mrun} <= 6'h0;
      {pcnt, tmr, ming, pass, maxc} <= 40'h0;
      vcall <= 4'h0;
      pcall <= 4'h0;
    end else if (CE) begin
      st <= next_st;
      pm <= next_pm;
      {cur, nxt, nok, mrun} <= {next_cur, next_nxt, next_nok, next_mrun};
      {pcnt, tmr, ming} <= {next_pcnt, next_tmr, next_ming};
      {pass, maxc} <= {next_pass, next_maxc};
      vcall <= next_vcall;
      pcall <= next_pcall;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      {GRN_OUT, YEL_OUT, WALK_OUT, PCLR_OUT} <= 16'h0;
      {CALL_OUT, ACTIVE_OUT, UPCOMING_OUT} <= 12'h0;
      RED_OUT <= 4'hf;
      DW_OUT <= 4'hf;
    end else if (CE) begin
      GRN_OUT <= p_grn;
      YEL_OUT <= p_yel;
      RED_OUT <= ~p_grn & ~p_yel;
      WALK_OUT <= p_wk;
      PCLR_OUT <= p_cl;
      DW_OUT <= p_dw;
      CALL_OUT <= p_chk;
      ACTIVE_OUT <= p_on;
      UPCOMING_OUT <= next_nok ? 4'h1 << next_nxt : 4'h0;
    end
  end

  // AXI4-Lite register access; one write and one read in flight
  logic [7:0]  aw_a;
  logic [31:0] w_d;
  logic [3:0]  w_s;
  logic        aw_h, w_h;
  wire wr_go = aw_h && w_h && !BVALID;
  wire [1:0] widx = aw_a[3:2];
  wire [1:0] ridx = ARADDR[3:2];
  wire w_cfg  = aw_a == `TPD_CFG_OFS;
  wire w_tima = aw_a[7:4] == `TPD_TIMA_OFS >> 4 && aw_a[1:0] == 2'h0;
  wire w_timb = aw_a[7:4] == `TPD_TIMB_OFS >> 4 && aw_a[1:0] == 2'h0;
  wire r_ok   = ARADDR == `TPD_CFG_OFS || ARADDR == `TPD_STAT_OFS ||
                (ARADDR[1:0] == 2'h0 && (ARADDR[7:4] == 4'h1 ||
                 ARADDR[7:4] == 4'h2));
  wire [31:0] stat = {12'h0, 4'(st), 2'h0, cur, 1'b0, nok, nxt,
                      pcall, vcall};
  wire [31:0] rd = ARADDR == `TPD_CFG_OFS ? cfg :
                   ARADDR == `TPD_STAT_OFS ? stat :
                   ARADDR[7:4] == 4'h1 ? tima[ridx] :
                   ARADDR[7:4] == 4'h2 ? timb[ridx] : 32'h0;

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      {aw_h, w_h, BVALID} <= 3'h0;
      AWREADY <= 1'b1;
      WREADY <= 1'b1;
      BRESP <= `TPD_RESP_OK;
      aw_a <= 8'h0;
      w_d <= 32'h0;
      w_s <= 4'h0;
      cfg <= `TPD_CFG_RST;
      for (int i = 0; i < 4; i++) begin
        tima[i] <= `TPD_TIMA_RST;
        timb[i] <= `TPD_TIMB_RST;
      end
    end else if (CE) begin
      if (AWVALID && AWREADY) begin
        {aw_h, AWREADY, aw_a} <= {2'b10, AWADDR};
      end
      if (WVALID && WREADY) begin
        {w_h, WREADY, w_d, w_s} <= {2'b10, WDATA, WSTRB};
      end
      if (wr_go) begin
        BVALID <= 1'b1;
        BRESP <= (w_cfg || w_tima || w_timb) ? `TPD_RESP_OK
                                             : `TPD_RESP_ERR;
        if (w_cfg) cfg <= merge(cfg, w_d, w_s);
        if (w_tima) tima[widx] <= merge(tima[widx], w_d, w_s);
        if (w_timb) timb[widx] <= merge(timb[widx], w_d, w_s);
      end
      if (BVALID && BREADY) begin
        {BVALID, aw_h, w_h} <= 3'h0;
        AWREADY <= 1'b1;
        WREADY <= 1'b1;
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      ARREADY <= 1'b1;
      RVALID <= 1'b0;
      RDATA <= 32'h0;
      RRESP <= `TPD_RESP_OK;
    end else if (CE) begin
      if (ARVALID && ARREADY) begin
        ARREADY <= 1'b0;
        RVALID <= 1'b1;
        RDATA <= rd;
        RRESP <= r_ok ? `TPD_RESP_OK : `TPD_RESP_ERR;
      end else if (RVALID && RREADY) begin
        ARREADY <= 1'b1;
        RVALID <= 1'b0;
      end
    end
  end

  // Checks; CE low voids any attempt spanning the frozen cycle
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST || !CE);

  wire lamp_ok = (GRN_OUT ^ YEL_OUT ^ RED_OUT) == 4'hf &&
                 (GRN_OUT & YEL_OUT) == 4'h0 && (GRN_OUT & RED_OUT) == 4'h0
                 && (YEL_OUT & RED_OUT) == 4'h0;
  sequence walk_held_s;
    st == S_WHOLD && hold;
  endsequence
  sequence hold_free_s;
    st == S_WHOLD && !hold;
  endsequence

  lamp_one_a: assert property (lamp_ok)
    else $error("vehicle lamps not exactly one per phase");
  ped_lamp_a: assert property (&(WALK_OUT | PCLR_OUT | DW_OUT))
    else $error("pedestrian lamps all dark");
  dw_steady_a: assert property (((DW_OUT ^ $past(DW_OUT)) &
    ~(PCLR_OUT | $past(PCLR_OUT) | WALK_OUT | $past(WALK_OUT))) == 4'h0)
    else $error("don't walk flashing outside clearance");
  walk_hold_a: assert property (walk_held_s |=> st == S_WHOLD)
    else $error("walk hold left while hold asserted");
  hold_rel_a: assert property (hold_free_s |=> st == S_PCLR ##1
    PCLR_OUT[$past(cur, 2)])
    else $error("hold release did not enter clearance");
  min_rest_a: assert property (st == S_PCLR && ming != 8'h00
    |=> st != S_GREST)
    else $error("green rest before minimum green");
  act_hold_a: assert property (st == S_GRN && hold |=> st == S_GRN)
    else $error("change interval entered under hold");
  call_out_a: assert property (vcall[3] && !g[3] && !vmoff[3] &&
    !p_grn[3] |=> CALL_OUT[3])
    else $error("call pending missing");
  skip_pick_a: assert property (end_grn && pk[2] |-> !skip[pk[1:0]])
    else $error("skipped phase selected");
  green_end_a: assert property (end_grn |=> st == S_YEL ##1
    YEL_OUT == 4'h1 << cur)
    else $error("green end did not reach yellow");
endmodule

// *** tb/tpd_field.sv ***
// Field side model: detector pins and a load-switch lamp monitor
// Assumes lamps are registered on the controller clock
module tpd_field (
  // Clocking
  input  wire logic       clk,
  input  wire logic       rst,
  // Requests from the bench
  input  wire logic [3:0] veh_req,
  input  wire logic [3:0] ped_req,
  // Detector pins
  output logic      [3:0] veh_det,
  output logic      [3:0] ped_det,
  // Lamp drivers watched
  input  wire logic [3:0] grn,
  input  wire logic [3:0] yel,
  input  wire logic [3:0] red,
  input  wire logic [3:0] walk,
  input  wire logic [3:0] pclr,
  input  wire logic [3:0] dw,
  // Lamp faults seen
  output logic      [7:0] faults
);
  timeunit 1ns;
  timeprecision 1ps;

  // Detectors are driven loops: level follows presence, no memory
  assign veh_det = veh_req;
  assign ped_det = ped_req;

  // Last cycle's lamps, kept by hand for simulators without $past
  logic [3:0] dw_q, pclr_q, walk_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      faults <= 8'h00;
      dw_q <= 4'hf;
      pclr_q <= 4'h0;
      walk_q <= 4'h0;
    end else begin
      dw_q <= dw;
      pclr_q <= pclr;
      walk_q <= walk;
      for (int i = 0; i < 4; i++) begin
        if (({1'b0, grn[i]} + {1'b0, yel[i]} + {1'b0, red[i]}) !== 2'h1)
          faults <= faults + 8'h01;
        if ((walk[i] | pclr[i] | dw[i]) !== 1'b1)
          faults <= faults + 8'h01;
        // A blink outside clearance would look like a stray toggle
        if (dw[i] !== dw_q[i] && !pclr[i] && !pclr_q[i] &&
            !walk[i] && !walk_q[i])
          faults <= faults + 8'h01;
      end
    end
  end
endmodule

// *** tb/traffic_phase_demand_logic_tb.sv ***
// Testbench for the phase demand controller, AXI4-Lite register access
// Assumes a short tick so that intervals last tens of cycles
`include "tpd_regs.svh"
module traffic_phase_demand_logic_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk, rst, hold, awvalid, wvalid, bready, arvalid, rready;
  logic        ce;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [3:0]  veh_req, ped_req, veh_det, ped_det, phase_skip, ped_skip;
  logic [3:0]  grn, yel, red, walk, pclr, dw, call, active, upcoming, wstrb;
  logic [7:0]  awaddr, araddr, faults;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  int          mismatches, comparisons;

  always #12.5 clk = ~clk;

  tpd_ctrl #(.TICK_CYC(8)) u_dut (
    .CORE_CLK(clk), .SYS_RST(rst), .CE(ce), .VEH_DET(veh_det),
    .PED_DET(ped_det), .HOLD(hold), .PED_RECYCLE(1'b0),
    .PHASE_SKIP(phase_skip), .PED_SKIP(ped_skip), .GRN_OUT(grn),
    .YEL_OUT(yel), .RED_OUT(red), .WALK_OUT(walk), .PCLR_OUT(pclr),
    .DW_OUT(dw), .CALL_OUT(call), .ACTIVE_OUT(active),
    .UPCOMING_OUT(upcoming), .AWADDR(awaddr), .AWVALID(awvalid),
    .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid),
    .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
    .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata),
    .RRESP(rresp), .RVALID(rvalid), .RREADY(rready));

  tpd_field u_field (
    .clk(clk), .rst(rst), .veh_req(veh_req), .ped_req(ped_req),
    .veh_det(veh_det), .ped_det(ped_det), .grn(grn), .yel(yel),
    .red(red), .walk(walk), .pclr(pclr), .dw(dw), .faults(faults));

  task report_and_stop;
    if (mismatches == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task timeout(input string name);
    mismatches++;
    $display("Error %s expected done seen timeout", name);
    report_and_stop();
  endtask

  task idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Address and data offered together, each dropped once taken
  task axi_write(input logic [7:0] a, input logic [31:0] d,
                 input logic [1:0] er);
    int n;
    // One edge apart, so a back-to-back call never re-drives bready
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hf;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    if (n == 100) timeout("bvalid");
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask

  task axi_read(input logic [7:0] a, input logic [31:0] exp,
                input logic [1:0] er);
    int n;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    if (n == 100) timeout("rvalid");
    chk("rdata", exp, rdata);
    chk("rresp", {30'h0, er}, {30'h0, rresp});
  endtask

  // Lamp select: 0 green, 1 walk, 2 clearance, 3 upcoming
  task wait_hi(input int sel, input int ph, input string name);
    int   n;
    logic v;
    for (n = 0; n < 3000; n++) begin
      @(posedge clk);
      v = sel == 0 ? grn[ph] : sel == 1 ? walk[ph] :
          sel == 2 ? pclr[ph] : upcoming[ph];
      if (v === 1'b1) break;
    end
    if (n == 3000) timeout(name);
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    timeout("run");
  end

  initial begin
    clk = 1'b0; rst = 1'b1; hold = 1'b0; veh_req = 4'h0; ped_req = 4'h0;
    phase_skip = 4'h0; ped_skip = 4'h0; awaddr = 8'h00; araddr = 8'h00;
    awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
    rready = 1'b0; wdata = 32'h0; wstrb = 4'h0;
    ce = 1'b1;
    mismatches = 0; comparisons = 0;
    idle(3);
    rst <= 1'b0;
    @(posedge clk);
    chk("red_rst", 32'hf, {28'h0, red});
    chk("dw_rst", 32'hf, {28'h0, dw});
    chk("status_rst", 32'h0, {16'h0, grn, call, active, upcoming});
    axi_read(`TPD_CFG_OFS, `TPD_CFG_RST, `TPD_RESP_OK);
    axi_read(`TPD_TIMA_OFS + 8'h0c, `TPD_TIMA_RST, `TPD_RESP_OK);
    axi_read(`TPD_TIMB_OFS, `TPD_TIMB_RST, `TPD_RESP_OK);
    axi_read(8'h40, 32'h0, `TPD_RESP_ERR);
    axi_write(`TPD_STAT_OFS, 32'hffffffff, `TPD_RESP_ERR);
    // Two-tick walk, clearance, passage; three-tick minimum green
    for (int i = 0; i < 4; i++) begin
      axi_write(`TPD_TIMA_OFS + 8'(4 * i), 32'h02030202, `TPD_RESP_OK);
      axi_write(`TPD_TIMB_OFS + 8'(4 * i), 32'h00020206, `TPD_RESP_OK);
    end
    axi_read(`TPD_TIMB_OFS + 8'h08, 32'h00020206, `TPD_RESP_OK);
    veh_req <= 4'h2;
    wait_hi(0, 1, "grn1");
    veh_req <= 4'h0;
    chk("active1", 32'h1, {31'h0, active[1]});
    chk("call1", 32'h0, {31'h0, call[1]});
    hold <= 1'b1;
    axi_write(`TPD_CFG_OFS, 32'h00f00008, `TPD_RESP_OK);
    veh_req <= 4'h8;
    idle(10);
    veh_req <= 4'h0;
    idle(20);
    chk("call3_nomem", 32'h0, {31'h0, call[3]});
    chk("grn1_hold", 32'h1, {31'h0, grn[1]});
    axi_write(`TPD_CFG_OFS, 32'h00f00080, `TPD_RESP_OK);
    idle(10);
    chk("call3_recall", 32'h1, {31'h0, call[3]});
    idle(200);
    chk("grn1_held", 32'h1, {31'h0, grn[1]});
    hold <= 1'b0;
    wait_hi(3, 3, "up3");
    wait_hi(0, 3, "grn3");
    chk("up3_done", 32'h0, {31'h0, upcoming[3]});
    axi_write(`TPD_CFG_OFS, `TPD_CFG_RST, `TPD_RESP_OK);
    phase_skip <= 4'h4;
    veh_req <= 4'h4;
    idle(10);
    veh_req <= 4'h0;
    idle(300);
    chk("call2_skip", 32'h1, {31'h0, call[2]});
    chk("grn3_skip", 32'h1, {31'h0, grn[3]});
    phase_skip <= 4'h0;
    wait_hi(0, 2, "grn2");
    ped_skip <= 4'h1;
    ped_req <= 4'h1;
    idle(10);
    ped_req <= 4'h0;
    idle(300);
    chk("call0_ped", 32'h1, {31'h0, call[0]});
    chk("walk0_skip", 32'h0, {31'h0, walk[0]});
    chk("grn2_skip", 32'h1, {31'h0, grn[2]});
    ped_skip <= 4'h0;
    wait_hi(1, 0, "walk0");
    chk("grn0_walk", 32'h1, {31'h0, grn[0]});
    wait_hi(2, 0, "pclr0");
    // Phase 1 nonactuated, minimum green longer than walk plus clearance
    axi_write(`TPD_TIMA_OFS + 8'h04, 32'h02140202, `TPD_RESP_OK);
    axi_write(`TPD_CFG_OFS, 32'h00f20000, `TPD_RESP_OK);
    wait_hi(1, 1, "walk1");
    hold <= 1'b1;
    idle(60);
    chk("walk1_hold", 32'h1, {31'h0, walk[1]});
    chk("grn1_walkhold", 32'h1, {31'h0, grn[1]});
    hold <= 1'b0;
    wait_hi(2, 1, "pclr1");
    idle(40);
    axi_read(`TPD_STAT_OFS, 32'h0002_1100, `TPD_RESP_OK);
    // Clock enable low must freeze the minimum green count
    ce <= 1'b0;
    idle(200);
    ce <= 1'b1;
    axi_read(`TPD_STAT_OFS, 32'h0002_1100, `TPD_RESP_OK);
    idle(100);
    axi_read(`TPD_STAT_OFS, 32'h0003_1100, `TPD_RESP_OK);
    idle(100);
    chk("lamp_faults", 32'h0, {24'h0, faults});
    report_and_stop();
  end
endmodule
